// [hw/lcle_pkg.sv]
// Purpose: Shared constants and types of the load, context and loop unit
// Assumes: Pre-decoded instruction fields arrive from the decode stage
// Notes: Register indices are 4 bits; 16 address and 16 data registers
package lcle_pkg;
  localparam int LCLE_DW = 32;
  localparam int LCLE_NREG = 16;
  localparam logic [31:0] LCLE_RESET_WORD = 32'h00000000;
  localparam logic [3:0] LCLE_A15_IDX = 4'hF;
  localparam logic [3:0] LCLE_D15_IDX = 4'hF;
  localparam logic [31:0] LCLE_POSTINC_STEP = 32'h00000004;
  localparam logic [31:0] LCLE_LEN_LONG = 32'h00000004;
  localparam logic [31:0] LCLE_LEN_SHORT = 32'h00000002;
  localparam logic [15:0] LCLE_LOW_HALF_ZERO = 16'h0000;
  // Context block: 16 words, words 0 and 1 not loaded
  localparam logic [3:0] LCLE_CTX_FIRST = 4'h2;
  localparam logic [3:0] LCLE_CTX_LAST = 4'hF;
  localparam logic [31:0] LCLE_CTX_FIRST_OFS = 32'h00000008;
  localparam logic [31:0] LCLE_WORD_STEP = 32'h00000004;

  typedef enum logic [3:0] {
    OP_LOAD_FRACTION_HALFWORD = 4'h0,
    OP_LOAD_WORD = 4'h1,
    OP_LOAD_WORD_SHORT = 4'h2,
    OP_LOWER_CONTEXT_RESTORE = 4'h3,
    OP_UPPER_CONTEXT_RESTORE = 4'h4,
    OP_MASKED_READ_MODIFY_WRITE = 4'h5,
    OP_EA_COMPUTE = 4'h6,
    OP_LOOP_LONG = 4'h7,
    OP_LOOP_SHORT = 4'h8
  } lcle_op_t;

  typedef enum logic [3:0] {
    MODE_DIRECT_ADDRESS = 4'h0,
    MODE_BASE_OFFSET = 4'h1,
    MODE_BASE_LONG_OFFSET = 4'h2,
    MODE_PRE_INCREMENT = 4'h3,
    MODE_POST_INCREMENT = 4'h4,
    MODE_SHORT_INDIRECT = 4'h5,
    MODE_SHORT_A15_OFFSET = 4'h6,
    MODE_SHORT_IMPLICIT_DEST = 4'h7,
    MODE_SHORT_POST_INCREMENT = 4'h8
  } lcle_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_READ = 3'h1,
    ST_EXEC = 3'h3,
    ST_MEM = 3'h2,
    ST_STORE = 3'h6,
    ST_CTX = 3'h7,
    ST_DONE = 3'h5
  } lcle_state_t;
endpackage

// [hw/lcle_rf_if.sv]
// Purpose: Carrier between the execution core and its register file
// Assumes: Read data are registered, one cycle after the index
// Notes: One write port serves both register banks
`timescale 1ns/1ps
interface lcle_rf_if;
  logic [3:0] rdAddrIdx;
  logic [3:0] rdDataIdx0;
  logic [3:0] rdDataIdx1;
  logic [31:0] rdAddrVal;
  logic [31:0] rdDataVal0;
  logic [31:0] rdDataVal1;
  logic wrEn;
  logic wrIsAddr;
  logic [3:0] wrIdx;
  logic [31:0] wrData;
  modport core (
    output rdAddrIdx, rdDataIdx0, rdDataIdx1, wrEn, wrIsAddr, wrIdx, wrData,
    input rdAddrVal, rdDataVal0, rdDataVal1
  );
  modport store (
    input rdAddrIdx, rdDataIdx0, rdDataIdx1, wrEn, wrIsAddr, wrIdx, wrData,
    output rdAddrVal, rdDataVal0, rdDataVal1
  );
endinterface

// [hw/lcle_regfile.sv]
// Purpose: Address and data register banks with registered reads
// Assumes: A read in the cycle of a write returns the old value
// Notes: Reset clears every register
`timescale 1ns/1ps
module lcle_regfile
  import lcle_pkg::*;
#(
  parameter int N_REGS = LCLE_NREG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Core side
  lcle_rf_if.store rf
);
  if (N_REGS != 16) begin : g_check
    $error("lcle_regfile serves exactly 16 registers per bank");
  end

  typedef struct packed {
    logic [N_REGS-1:0][31:0] addrReg;
    logic [N_REGS-1:0][31:0] dataReg;
    logic [31:0] rdA;
    logic [31:0] rdD0;
    logic [31:0] rdD1;
  } lcle_rf_t;

  lcle_rf_t s_q;
  lcle_rf_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdA = s_q.addrReg[rf.rdAddrIdx];
    s_d.rdD0 = s_q.dataReg[rf.rdDataIdx0];
    s_d.rdD1 = s_q.dataReg[rf.rdDataIdx1];
    for (int i = 0; i < N_REGS; i++) begin
      if (rf.wrEn && rf.wrIdx == 4'(i)) begin
        if (rf.wrIsAddr) begin
          s_d.addrReg[i] = rf.wrData;
        end else begin
          s_d.dataReg[i] = rf.wrData;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rf.rdAddrVal = s_q.rdA;
  assign rf.rdDataVal0 = s_q.rdD0;
  assign rf.rdDataVal1 = s_q.rdD1;
endmodule

// [hw/lcle_exec.sv]
// Purpose: Executes loads, context restores, masked update, address
//   compute and loop branches for the core
// Assumes: Memory answers each request with a one-cycle memAck
// Notes: One instruction at a time; insnReady shows acceptance
`timescale 1ns/1ps

// Functional notes
// - Fraction halfword load puts the halfword in bits 31:16, zeros below.
// - Long word load writes the fetched word unchanged into the data reg.
// - Long-offset mode address is base plus sign-extended 16-bit offset.
// - Short offset and pre-increment add a signed 10-bit offset; post uses base.
// - Short word load offers base indirect and A15 plus unsigned 4-bit offset.
// - Short post-increment load uses the old base, then adds 4 to it.
// - Lower restore fills address regs 2 to 7 and data regs 0 to 7.
// - Upper restore fills address regs 10 to 15 and data regs 8 to 15.
// - Restores accept only direct address and base plus short offset.
// - Masked update keeps bits where the odd mask is 0, takes even value.
// - Address compute writes the address into an address reg, no access.
// - Long loop adds twice the signed 15-bit displacement to the PC.
// - Short loop adds twice the 4-bit displacement, one-extended, to PC.
// - Both loops test the old register value, then decrement it.
module lcle_exec
  import lcle_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Instruction from decode
  input wire logic insnValid,
  input wire lcle_op_t insnOp,
  input wire lcle_mode_t insnMode,
  input wire logic [3:0] insnRegA,
  input wire logic [3:0] insnRegB,
  input wire logic [15:0] insnOffset,
  input wire logic [31:0] insnAbsAddr,
  input wire logic [31:0] insnPc,
  output logic insnReady,
  // Memory port
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  // Completion
  output logic done,
  output logic illegal,
  output logic branchTaken,
  output logic [31:0] pcNext
);
  typedef struct packed {
    lcle_state_t st;
    lcle_op_t op;
    lcle_mode_t mode;
    logic [3:0] regA;
    logic [3:0] regB;
    logic [15:0] ofs;
    logic [31:0] absAddr;
    logic [31:0] pc;
    logic [3:0] cnt;
    logic ready;
    logic memReq;
    logic memWrite;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic done;
    logic illegal;
    logic taken;
    logic [31:0] pcNext;
  } lcle_core_t;

  lcle_core_t s_q;
  lcle_core_t s_d;
  lcle_rf_if rfBus ();

  logic wrEn;
  logic wrIsAddr;
  logic [3:0] wrIdx;
  logic [31:0] wrData;
  logic [31:0] ea;
  logic [31:0] loopDisp;
  logic [31:0] mask;
  logic [31:0] insVal;

  function automatic logic [31:0] sext10(input logic [15:0] o);
    sext10 = {{22{o[9]}}, o[9:0]};
  endfunction

  function automatic logic isShortMode(input lcle_mode_t m);
    isShortMode = (m == MODE_SHORT_INDIRECT) ||
      (m == MODE_SHORT_A15_OFFSET) || (m == MODE_SHORT_IMPLICIT_DEST) ||
      (m == MODE_SHORT_POST_INCREMENT);
  endfunction

  function automatic logic modeOk(input lcle_op_t o, input lcle_mode_t m);
    unique case (o)
      OP_LOWER_CONTEXT_RESTORE, OP_UPPER_CONTEXT_RESTORE: begin
        modeOk = (m == MODE_DIRECT_ADDRESS) || (m == MODE_BASE_OFFSET);
      end
      OP_LOAD_WORD_SHORT: begin
        modeOk = isShortMode(m);
      end
      OP_LOAD_WORD, OP_EA_COMPUTE: begin
        modeOk = !isShortMode(m);
      end
      OP_LOAD_FRACTION_HALFWORD, OP_MASKED_READ_MODIFY_WRITE: begin
        modeOk = !isShortMode(m) && (m != MODE_BASE_LONG_OFFSET);
      end
      OP_LOOP_LONG, OP_LOOP_SHORT: begin
        modeOk = 1'b1;
      end
      default: begin
        modeOk = 1'b0;
      end
    endcase
  endfunction

  // Register indices read while an instruction is held
  always_comb begin
    rfBus.rdAddrIdx = s_q.regB;
    if (s_q.op == OP_LOOP_LONG || s_q.op == OP_LOOP_SHORT) begin
      rfBus.rdAddrIdx = s_q.regA;
    end else if (s_q.mode == MODE_SHORT_A15_OFFSET) begin
      rfBus.rdAddrIdx = LCLE_A15_IDX;
    end
  end
  assign rfBus.rdDataIdx0 = {s_q.regA[3:1], 1'b0};
  assign rfBus.rdDataIdx1 = {s_q.regA[3:1], 1'b1};
  assign mask = rfBus.rdDataVal1;
  assign insVal = rfBus.rdDataVal0;

  // Effective address of the held instruction
  always_comb begin
    ea = rfBus.rdAddrVal;
    unique case (s_q.mode)
      MODE_DIRECT_ADDRESS: begin
        ea = s_q.absAddr;
      end
      MODE_BASE_OFFSET, MODE_PRE_INCREMENT: begin
        ea = rfBus.rdAddrVal + sext10(s_q.ofs);
      end
      MODE_BASE_LONG_OFFSET: begin
        ea = rfBus.rdAddrVal + {{16{s_q.ofs[15]}}, s_q.ofs};
      end
      MODE_SHORT_A15_OFFSET, MODE_SHORT_IMPLICIT_DEST: begin
        ea = rfBus.rdAddrVal + {28'h0000000, s_q.ofs[3:0]};
      end
      default: begin
        ea = rfBus.rdAddrVal;
      end
    endcase
  end

  always_comb begin
    if (s_q.op == OP_LOOP_SHORT) begin
      loopDisp = {27'h7FFFFFF, s_q.ofs[3:0], 1'b0};
    end else begin
      loopDisp = {{16{s_q.ofs[14]}}, s_q.ofs[14:0], 1'b0};
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    wrEn = 1'b0;
    wrIsAddr = 1'b0;
    wrIdx = s_q.regA;
    wrData = LCLE_RESET_WORD;
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (insnValid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.op = insnOp;
          s_d.mode = insnMode;
          s_d.regA = insnRegA;
          s_d.regB = insnRegB;
          s_d.ofs = insnOffset;
          s_d.absAddr = insnAbsAddr;
          s_d.pc = insnPc;
          s_d.illegal = 1'b0;
          s_d.taken = 1'b0;
          s_d.st = ST_READ;
        end
      end
      ST_READ: begin
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        s_d.pcNext = s_q.pc + ((s_q.op == OP_LOAD_WORD_SHORT ||
          s_q.op == OP_LOOP_SHORT) ? LCLE_LEN_SHORT : LCLE_LEN_LONG);
        if (!modeOk(s_q.op, s_q.mode)) begin
          s_d.illegal = 1'b1;
          s_d.done = 1'b1;
          s_d.st = ST_DONE;
        end else if (s_q.op == OP_EA_COMPUTE) begin
          wrEn = 1'b1;
          wrIsAddr = 1'b1;
          wrData = ea;
          s_d.done = 1'b1;
          s_d.st = ST_DONE;
        end else if (s_q.op == OP_LOOP_LONG || s_q.op == OP_LOOP_SHORT) begin
          wrEn = 1'b1;
          wrIsAddr = 1'b1;
          wrData = rfBus.rdAddrVal - 32'h00000001;
          if (rfBus.rdAddrVal != LCLE_RESET_WORD) begin
            s_d.taken = 1'b1;
            s_d.pcNext = s_q.pc + loopDisp;
          end
          s_d.done = 1'b1;
          s_d.st = ST_DONE;
        end else begin
          wrIdx = s_q.regB;
          wrIsAddr = 1'b1;
          if (s_q.mode == MODE_PRE_INCREMENT ||
              s_q.mode == MODE_POST_INCREMENT) begin
            wrEn = 1'b1;
            wrData = rfBus.rdAddrVal + sext10(s_q.ofs);
          end else if (s_q.mode == MODE_SHORT_POST_INCREMENT) begin
            wrEn = 1'b1;
            wrData = rfBus.rdAddrVal + LCLE_POSTINC_STEP;
          end
          s_d.memReq = 1'b1;
          s_d.memWrite = 1'b0;
          s_d.memAddr = ea;
          s_d.st = ST_MEM;
          if (s_q.op == OP_LOWER_CONTEXT_RESTORE ||
              s_q.op == OP_UPPER_CONTEXT_RESTORE) begin
            s_d.cnt = LCLE_CTX_FIRST;
            s_d.memAddr = ea + LCLE_CTX_FIRST_OFS;
            s_d.st = ST_CTX;
          end
        end
      end
      ST_MEM: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_DONE;
          wrEn = 1'b1;
          wrData = memRdata;
          if (s_q.op == OP_MASKED_READ_MODIFY_WRITE) begin
            wrEn = 1'b0;
            s_d.done = 1'b0;
            s_d.memReq = 1'b1;
            s_d.memWrite = 1'b1;
            s_d.memWdata = (memRdata & ~mask) | (insVal & mask);
            s_d.st = ST_STORE;
          end else if (s_q.op == OP_LOAD_FRACTION_HALFWORD) begin
            wrData = {memRdata[15:0], LCLE_LOW_HALF_ZERO};
          end else if (s_q.mode == MODE_SHORT_IMPLICIT_DEST) begin
            wrIdx = LCLE_D15_IDX;
          end
        end
      end
      ST_STORE: begin
        if (memAck) begin
          s_d.memReq = 1'b0;
          s_d.memWrite = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_DONE;
        end
      end
      ST_CTX: begin
        if (memAck) begin
          wrEn = 1'b1;
          wrIsAddr = !s_q.cnt[3];
          wrData = memRdata;
          if (s_q.op == OP_UPPER_CONTEXT_RESTORE) begin
            wrIdx = {1'b1, s_q.cnt[2:0]};
          end else begin
            wrIdx = {1'b0, s_q.cnt[2:0]};
          end
          if (s_q.cnt == LCLE_CTX_LAST) begin
            s_d.memReq = 1'b0;
            s_d.done = 1'b1;
            s_d.st = ST_DONE;
          end else begin
            s_d.cnt = s_q.cnt + 4'h1;
            s_d.memAddr = s_q.memAddr + LCLE_WORD_STEP;
          end
        end
      end
      ST_DONE: begin
        s_d.ready = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.memReq = 1'b0;
        s_d.memWrite = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rfBus.wrEn = wrEn;
  assign rfBus.wrIsAddr = wrIsAddr;
  assign rfBus.wrIdx = wrIdx;
  assign rfBus.wrData = wrData;

  lcle_regfile #(
    .N_REGS(LCLE_NREG)
  ) u_regfile (
    .clk(clk),
    .arst_n(arst_n),
    .rf(rfBus.store)
  );

  assign insnReady = s_q.ready;
  assign memReq = s_q.memReq;
  assign memWrite = s_q.memWrite;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign done = s_q.done;
  assign illegal = s_q.illegal;
  assign branchTaken = s_q.taken;
  assign pcNext = s_q.pcNext;
endmodule

// [tb/lcle_exec_sva.sv]
// Purpose: Port checks on the load, context and loop unit
// Assumes: Instruction fields are captured at the take edge
// Notes: Restore steps assume a 16-word aligned block
`timescale 1ns/1ps
module lcle_exec_chk
  import lcle_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Instruction
  input wire logic insnValid,
  input wire lcle_op_t insnOp,
  input wire lcle_mode_t insnMode,
  input wire logic [15:0] insnOffset,
  input wire logic [31:0] insnPc,
  input wire logic insnReady,
  // Memory and completion
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic done,
  input wire logic illegal,
  input wire logic branchTaken,
  input wire logic [31:0] pcNext
);
  lcle_op_t opCap_q;
  lcle_mode_t mdCap_q;
  logic [15:0] ofsCap_q;
  logic [31:0] pcCap_q;
  logic isCtx;
  assign isCtx = opCap_q == OP_LOWER_CONTEXT_RESTORE ||
    opCap_q == OP_UPPER_CONTEXT_RESTORE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opCap_q <= OP_LOAD_FRACTION_HALFWORD;
      mdCap_q <= MODE_DIRECT_ADDRESS;
      ofsCap_q <= 16'h0000;
      pcCap_q <= 32'h00000000;
    end else if (insnValid && insnReady) begin
      opCap_q <= insnOp;
      mdCap_q <= insnMode;
      ofsCap_q <= insnOffset;
      pcCap_q <= insnPc;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_req_held: assert property (memReq && !memAck |=> memReq &&
    $stable(memAddr) && $stable(memWrite)) else $error("request moved");
  a_ea_quiet: assert property (insnValid && insnReady &&
    insnOp == OP_EA_COMPUTE |=> !memReq [*3]) else $error("ea accessed");
  a_loop_time: assert property (insnValid && insnReady &&
    (insnOp == OP_LOOP_LONG || insnOp == OP_LOOP_SHORT) |-> ##3 done)
    else $error("loop not done in three");
  a_long_target: assert property (done && opCap_q == OP_LOOP_LONG &&
    branchTaken |-> pcNext == pcCap_q + {{16{ofsCap_q[14]}},
    ofsCap_q[14:0], 1'b0}) else $error("long loop target");
  a_long_fall: assert property (done && opCap_q == OP_LOOP_LONG &&
    !branchTaken |-> pcNext == pcCap_q + 32'h00000004)
    else $error("long loop fall through");
  a_short_back: assert property (done && opCap_q == OP_LOOP_SHORT &&
    branchTaken |-> pcNext == pcCap_q + {27'h7FFFFFF, ofsCap_q[3:0], 1'b0})
    else $error("short loop target");
  a_write_rmw: assert property (memReq && memWrite |->
    opCap_q == OP_MASKED_READ_MODIFY_WRITE) else $error("stray write");
  a_ctx_mode: assert property (done && isCtx && !(mdCap_q inside
    {MODE_DIRECT_ADDRESS, MODE_BASE_OFFSET}) |-> illegal)
    else $error("restore mode accepted");
  a_ctx_step: assert property (memReq && memAck && isCtx &&
    memAddr[5:2] != 4'hF |=> memReq && memAddr == $past(memAddr) +
    32'h00000004) else $error("restore address step");
endmodule
bind lcle_exec lcle_exec_chk u_chk (.clk(clk), .arst_n(arst_n),
  .insnValid(insnValid), .insnOp(insnOp), .insnMode(insnMode),
  .insnOffset(insnOffset), .insnPc(insnPc), .insnReady(insnReady),
  .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
  .memAck(memAck), .done(done), .illegal(illegal),
  .branchTaken(branchTaken), .pcNext(pcNext));

// [tb/lcle_mem_model.sv]
// Purpose: Data memory answering the unit's requests
// Assumes: Read word is the address xor a fixed pattern
// Notes: Data line toggles when no answer is given
`timescale 1ns/1ps
module lcle_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request side
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic slow,
  // Answer side
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [1:0] wait_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memAck <= 1'b0;
      memRdata <= 32'h00000000;
      wait_q <= 2'h0;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) begin
        if (wait_q == (slow ? 2'h3 : 2'h0)) begin
          memAck <= 1'b1;
          wait_q <= 2'h0;
          if (!memWrite) memRdata <= memAddr ^ 32'hC3C30000;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench of the execution unit
// Assumes: Register file is zero after reset
// Notes: Tests run in order and share register state
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
  badCount++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb
  import lcle_pkg::*;
;
  logic clk, arst_n, insnValid, insnReady, memReq, memWrite, memAck, slow;
  logic done, illegal, branchTaken;
  lcle_op_t insnOp;
  lcle_mode_t insnMode;
  logic [3:0] insnRegA, insnRegB;
  logic [15:0] insnOffset;
  logic [31:0] insnAbsAddr, insnPc, memAddr, memWdata, memRdata, pcNext;
  logic [31:0] qa[$], qd[$];
  logic qw[$];
  int badCount, checks, cyc;
  lcle_exec DUT (.clk(clk), .arst_n(arst_n), .insnValid(insnValid),
    .insnOp(insnOp), .insnMode(insnMode), .insnRegA(insnRegA),
    .insnRegB(insnRegB), .insnOffset(insnOffset), .insnAbsAddr(insnAbsAddr),
    .insnPc(insnPc), .insnReady(insnReady), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .done(done), .illegal(illegal),
    .branchTaken(branchTaken), .pcNext(pcNext));
  lcle_mem_model u_mem (.clk(clk), .arst_n(arst_n), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .slow(slow), .memAck(memAck),
    .memRdata(memRdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (memReq === 1'b1 && memAck === 1'b1) begin
      qa.push_back(memAddr);
      qd.push_back(memWdata);
      qw.push_back(memWrite);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run(input lcle_op_t op, input lcle_mode_t md,
    input logic [3:0] ra, input logic [3:0] rb, input logic [15:0] ofs,
    input logic [31:0] ab, input logic [31:0] pc);
    int n;
    qa.delete();
    qd.delete();
    qw.delete();
    insnOp = op;
    insnMode = md;
    {insnRegA, insnRegB} = {ra, rb};
    {insnOffset, insnAbsAddr, insnPc} = {ofs, ab, pc};
    insnValid = 1'b1;
    while (insnReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    insnValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    `CHK("done", 1'b1, done)
  endtask
  task automatic ld(input lcle_mode_t md, input logic [3:0] rb,
    input logic [15:0] ofs, input logic [31:0] addr);
    run(md > MODE_POST_INCREMENT ? OP_LOAD_WORD_SHORT : OP_LOAD_WORD, md,
      4'h7, rb, ofs, 32'h00000000, 32'h00000000);
    `CHK("loadAddr", addr, qa[0])
  endtask
  task automatic test_addr();
    run(OP_EA_COMPUTE, MODE_DIRECT_ADDRESS, 4'h2, 4'h0, 16'h0000,
      32'h00002000, 32'h00000000);
    `CHK("eaTraffic", 0, qa.size())
    ld(MODE_BASE_OFFSET, 4'h2, 16'h03FC, 32'h00001FFC);
    ld(MODE_BASE_LONG_OFFSET, 4'h2, 16'h8000, 32'hFFFFA000);
    ld(MODE_PRE_INCREMENT, 4'h2, 16'h0010, 32'h00002010);
    ld(MODE_SHORT_INDIRECT, 4'h2, 16'h0000, 32'h00002010);
    ld(MODE_POST_INCREMENT, 4'h2, 16'h0008, 32'h00002010);
    ld(MODE_SHORT_INDIRECT, 4'h2, 16'h0000, 32'h00002018);
    ld(MODE_SHORT_POST_INCREMENT, 4'h2, 16'h0000, 32'h00002018);
    ld(MODE_SHORT_INDIRECT, 4'h2, 16'h0000, 32'h0000201C);
    ld(MODE_SHORT_IMPLICIT_DEST, 4'h2, 16'h0004, 32'h00002020);
    ld(MODE_SHORT_A15_OFFSET, 4'h2, 16'h000C, 32'h0000000C);
    $display("test addressing finished");
  endtask
  task automatic test_rmw();
    run(OP_LOAD_FRACTION_HALFWORD, MODE_BASE_OFFSET, 4'h4, 4'h2, 16'h0000,
      32'h00000000, 32'h00000000);
    run(OP_LOAD_WORD, MODE_DIRECT_ADDRESS, 4'h5, 4'h0, 16'h0000,
      32'hFFFF0F0F, 32'h00000000);
    run(OP_MASKED_READ_MODIFY_WRITE, MODE_BASE_OFFSET, 4'h4, 4'h2,
      16'h0004, 32'h00000000, 32'h00000000);
    `CHK("rmwCount", 2, qa.size())
    `CHK("rmwAddr", 32'h00002020, qa[1])
    `CHK("rmwKind", 2'b01, {qw[0], qw[1]})
    `CHK("rmwData", 32'hE3DF2020, qd[1])
    $display("test masked update finished");
  endtask
  task automatic test_loop();
    run(OP_LOOP_LONG, MODE_DIRECT_ADDRESS, 4'h3, 4'h0, 16'h7FFE,
      32'h00000000, 32'h00000100);
    `CHK("loopFall", 33'h000000104, {branchTaken, pcNext})
    run(OP_LOOP_LONG, MODE_DIRECT_ADDRESS, 4'h3, 4'h0, 16'h7FFE,
      32'h00000000, 32'h00000100);
    `CHK("loopLong", 33'h1000000FC, {branchTaken, pcNext})
    run(OP_LOOP_SHORT, MODE_DIRECT_ADDRESS, 4'h3, 4'h0, 16'h0005,
      32'h00000000, 32'h00000200);
    `CHK("loopShort", 33'h1000001EA, {branchTaken, pcNext})
    `CHK("loopTraffic", 0, qa.size())
    ld(MODE_SHORT_INDIRECT, 4'h3, 16'h0000, 32'hFFFFFFFD);
    $display("test loops finished");
  endtask
  task automatic test_ctx();
    slow = 1'b1;
    run(OP_LOWER_CONTEXT_RESTORE, MODE_DIRECT_ADDRESS, 4'h0, 4'h0,
      16'h0000, 32'h00000400, 32'h00000000);
    `CHK("lowCount", 14, qa.size())
    for (int k = 0; k < 14; k++) `CHK("lowAddr", 32'h408 + 4 * k, qa[k])
    ld(MODE_SHORT_INDIRECT, 4'h2, 16'h0000, 32'hC3C30408);
    run(OP_UPPER_CONTEXT_RESTORE, MODE_BASE_LONG_OFFSET, 4'h0, 4'h0,
      16'h0040, 32'h00000000, 32'h00000000);
    `CHK("badMode", 33'h100000000, {illegal, qa.size()})
    run(OP_UPPER_CONTEXT_RESTORE, MODE_BASE_OFFSET, 4'h0, 4'h0, 16'h0040,
      32'h00000000, 32'h00000000);
    `CHK("upCount", 33'h00000000E, {illegal, qa.size()})
    `CHK("upFirst", 32'h00000048, qa[0])
    ld(MODE_SHORT_INDIRECT, 4'hF, 16'h0000, 32'hC3C3005C);
    slow = 1'b0;
    $display("test restores finished");
  endtask
  initial begin
    {arst_n, insnValid, slow, insnRegA, insnRegB} = '0;
    insnOp = OP_LOAD_WORD;
    insnMode = MODE_DIRECT_ADDRESS;
    {insnOffset, insnAbsAddr, insnPc} = '0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    test_addr();
    test_rmw();
    test_loop();
    test_ctx();
    report_and_stop();
  end
endmodule
